// [design/srcp_defs.svh]
/*
 header of constants for the serial register control port: frame sizes,
 clock ratios and the 125 MHz system clock figures.
 assumes inclusion by bare name from both ends.
*/
`ifndef SRCP_DEFS_SVH
`define SRCP_DEFS_SVH
`define SRCP_WORD_BITS    8
`define SRCP_FRAME_BITS   16
`define SRCP_ADDR_MSB     15
`define SRCP_ADDR_LSB     8
`define SRCP_NUM_REGS     128
`define SRCP_SYS_CLK_MHZ  125
`define SRCP_SCLK_MAX_MHZ 11
// half serial period in system cycles, rounded up so the port stays under 11 MHz
`define SRCP_SCLK_HALF    ((`SRCP_SYS_CLK_MHZ + 2*`SRCP_SCLK_MAX_MHZ - 1) / (2*`SRCP_SCLK_MAX_MHZ))
`define SRCP_MCLK_DIV2    1
`define SRCP_MCLK_DIV4    2
`endif

// [design/srcp_pkg.sv]
/*
 types shared by both ends of the serial register control port.
 assumes srcp_defs.svh for widths.
*/
package srcp_pkg;
   typedef enum {
      SRCP_DEV_IDLE,
      SRCP_DEV_ADDR,
      SRCP_DEV_DATA,
      SRCP_DEV_DONE
   } srcp_dev_state_t;
   typedef enum {
      SRCP_CTL_IDLE,
      SRCP_CTL_LOW,
      SRCP_CTL_HIGH,
      SRCP_CTL_END
   } srcp_ctl_state_t;
endpackage : srcp_pkg

// [design/srcp_if.sv]
/*
 four-wire serial control link between controller and device.
 the bench resolves io_i from the two output enables.
*/
`timescale 1ns/1ps
interface srcp_if;
   logic sclk;
   logic cs_n;
   logic rd_wr;
   logic io_ctl_o;
   logic io_ctl_oe;
   logic io_dev_o;
   logic io_dev_oe;
   logic io_i;
   modport device (
      input  sclk,
      input  cs_n,
      input  rd_wr,
      input  io_i,
      output io_dev_o,
      output io_dev_oe
   );
   modport controller (
      output sclk,
      output cs_n,
      output rd_wr,
      output io_ctl_o,
      output io_ctl_oe,
      input  io_i
   );
endinterface : srcp_if

// [design/srcp_device.sv]
/*
 device end of the serial register control port: register file,
 serial slave, transceiver enable and master clock division.
 assumes the controller keeps cs_n low for a whole frame and respects
 the serial clock limit; link pins are synchronised into i_sys_clk.
*/
// Contract
// [R1] words shift most significant bit first
// [R2] frame is address byte then data byte
// [R3] data pin driven only while direction high
// [R4] data sampled on rising serial clock
// [R5] serial pins synchronised into master clock
// [R6] controller keeps serial clock within limits
// [R7] direction high reads, low writes
// [R8] controller sets direction before rising edge
// [R9] port responds only while select low
// [R10] select leaves transmit and receive alone
// [R11] reset disables transceiver, held gives standby
// [R12] reset leaves configuration registers untouched
// [R13] transceiver clocks are master divided by two/four
// [R14] select high resets the serial sequencer
// [R15] address bit zero is ignored
// [R16] controller programs only out of reset
// [R17] device launches read data on rising edges
// [R18] read returns contents, write after eight bits
`timescale 1ns/1ps
`include "srcp_defs.svh"
module srcp_device (
   // clock and reset
   input  wire logic       i_sys_clk,
   input  wire logic       i_reset_n,
   // serial link
   srcp_if.device          link,
   // transceiver side
   input  wire logic       i_clk_div4_sel,
   output logic            o_xcvr_enable,
   output logic            o_standby,
   output logic            o_xcvr_clk,
   output logic [7:0]      o_reg_view_data,
   input  wire logic [6:0] i_reg_view_index
);
   typedef struct packed {
      logic [1:0]              sclk_s;
      logic [1:0]              cs_s;
      logic [1:0]              rw_s;
      logic [1:0]              io_s;
      logic                    sclk_d;
      srcp_pkg::srcp_dev_state_t st;
      logic [3:0]              cnt;
      logic [7:0]              addr;
      logic [7:0]              shreg;
      logic                    io_o;
      logic                    io_oe;
      logic [1:0]              div;
      logic                    xen;
      logic                    stby;
      logic [7:0]              view;
   } srcp_dev_state_s_t;

   srcp_dev_state_s_t state_r;
   srcp_dev_state_s_t state_nxt;
   // no reset on the array: configuration survives master reset
   logic [7:0]        regs_r [`SRCP_NUM_REGS]; // R12
   logic              wr_en;
   logic [6:0]        wr_idx;
   logic [7:0]        wr_val;

   logic sclk_rise;
   logic cs_on;
   assign sclk_rise = state_r.sclk_s[1] & ~state_r.sclk_d;   // R4
   assign cs_on     = ~state_r.cs_s[1];                      // R9

   always_comb begin
      state_nxt        = state_r;
      wr_en            = 1'b0;
      wr_idx           = state_r.addr[7:1];                  // R15
      wr_val           = state_r.shreg;
      // two flops before any logic reads the link pins
      state_nxt.sclk_s = {state_r.sclk_s[0], link.sclk};     // R5
      state_nxt.cs_s   = {state_r.cs_s[0], link.cs_n};
      state_nxt.rw_s   = {state_r.rw_s[0], link.rd_wr};
      state_nxt.io_s   = {state_r.io_s[0], link.io_i};
      state_nxt.sclk_d = state_r.sclk_s[1];
      state_nxt.div    = state_r.div + 2'h1;                 // R13
      state_nxt.xen    = 1'b1;
      state_nxt.stby   = 1'b0;
      state_nxt.view   = regs_r[i_reg_view_index];
      if (!cs_on) begin
         state_nxt.st    = srcp_pkg::SRCP_DEV_IDLE;          // R14
         state_nxt.cnt   = 4'h0;
         state_nxt.io_oe = 1'b0;
      end else begin
         case (state_r.st)
            srcp_pkg::SRCP_DEV_IDLE: begin
               state_nxt.st  = srcp_pkg::SRCP_DEV_ADDR;
               state_nxt.cnt = 4'h0;
            end
            srcp_pkg::SRCP_DEV_ADDR: begin
               if (sclk_rise) begin
                  state_nxt.addr = {state_r.addr[6:0], state_r.io_s[1]}; // R1
                  state_nxt.cnt  = state_r.cnt + 4'h1;
                  if (state_r.cnt == 4'h7) begin
                     state_nxt.st  = srcp_pkg::SRCP_DEV_DATA; // R2
                     state_nxt.cnt = 4'h0;
                     // load read value; bit 7 goes out on this very edge
                     // index is address bits 7:1, the seven bits already shifted in
                     state_nxt.shreg = regs_r[state_r.addr[6:0]];     // R15 R18
                     state_nxt.io_o  = regs_r[state_r.addr[6:0]][7];  // R17
                  end
               end
            end
            srcp_pkg::SRCP_DEV_DATA: begin
               if (sclk_rise) begin
                  state_nxt.cnt = state_r.cnt + 4'h1;
                  if (state_r.rw_s[1]) begin                 // R7
                     state_nxt.shreg = {state_r.shreg[6:0], 1'b0};
                     state_nxt.io_o  = state_r.shreg[6];     // R17
                  end else begin
                     state_nxt.shreg = {state_r.shreg[6:0], state_r.io_s[1]}; // R1
                  end
                  if (state_r.cnt == 4'h7) begin
                     state_nxt.st = srcp_pkg::SRCP_DEV_DONE;
                     if (!state_r.rw_s[1]) begin
                        wr_en  = 1'b1;                       // R18
                        wr_val = {state_r.shreg[6:0], state_r.io_s[1]};
                     end
                  end
               end
            end
            srcp_pkg::SRCP_DEV_DONE: begin
               state_nxt.io_oe = 1'b0;
            end
            default: begin
               state_nxt.st = srcp_pkg::SRCP_DEV_IDLE;
            end
         endcase
         // enable rises with bit 7: one cycle later costs the controller's sample
         state_nxt.io_oe = state_r.rw_s[1] &&                // R3
                           (state_nxt.st == srcp_pkg::SRCP_DEV_DATA);
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state_r      <= '0;
         state_r.cs_s <= 2'h3;
         state_r.st   <= srcp_pkg::SRCP_DEV_IDLE;
         state_r.stby <= 1'b1;                               // R11
         state_r.xen  <= 1'b0;                               // R11
      end else begin
         state_r <= state_nxt;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (wr_en) begin
         regs_r[wr_idx] <= wr_val;
      end
   end

   // select feeds only the serial sequencer, never the transceiver path
   assign o_xcvr_enable   = state_r.xen;                     // R10
   assign o_standby       = state_r.stby;
   assign o_xcvr_clk      = i_clk_div4_sel ? state_r.div[`SRCP_MCLK_DIV4-1]
                                           : state_r.div[`SRCP_MCLK_DIV2-1]; // R13
   assign o_reg_view_data = state_r.view;
   assign link.io_dev_o   = state_r.io_o;
   assign link.io_dev_oe  = state_r.io_oe;
endmodule : srcp_device

// [design/srcp_controller.sv]
/*
 controller end of the serial register control port: runs one
 address/data frame per request, drives on falling serial edges.
 assumes requests come from logic on i_sys_clk.
*/
`timescale 1ns/1ps
`include "srcp_defs.svh"
module srcp_controller (
   // clock and reset
   input  wire logic       i_sys_clk,
   input  wire logic       i_reset_n,
   // request side
   input  wire logic       i_req_valid,
   input  wire logic       i_req_read,
   input  wire logic [7:0] i_req_addr,
   input  wire logic [7:0] i_req_wdata,
   output logic            o_req_ready,
   output logic            o_done,
   output logic [7:0]      o_rdata,
   // serial link
   srcp_if.controller      link
);
   typedef struct packed {
      srcp_pkg::srcp_ctl_state_t st;
      logic [3:0]  half;
      logic [4:0]  bitn;
      logic [15:0] shreg;
      logic [7:0]  rdata;
      logic        rd;
      logic        sclk;
      logic        cs_n;
      logic        done;
      logic [1:0]  io_s;
   } srcp_ctl_state_s_t;

   srcp_ctl_state_s_t state_r;
   srcp_ctl_state_s_t state_nxt;

   always_comb begin
      state_nxt      = state_r;
      state_nxt.done = 1'b0;
      state_nxt.io_s = {state_r.io_s[0], link.io_i};
      state_nxt.half = state_r.half + 4'h1;
      case (state_r.st)
         srcp_pkg::SRCP_CTL_IDLE: begin
            state_nxt.half = 4'h0;
            if (i_req_valid) begin
               state_nxt.st    = srcp_pkg::SRCP_CTL_LOW;
               state_nxt.cs_n  = 1'b0;                       // R14
               state_nxt.rd    = i_req_read;                 // R8
               state_nxt.shreg = {i_req_addr, i_req_wdata};  // R2
               state_nxt.bitn  = 5'h0;
            end
         end
         srcp_pkg::SRCP_CTL_LOW: begin
            // half period sized so the clock stays under its limit
            if (state_r.half == 4'(`SRCP_SCLK_HALF - 1)) begin // R6
               state_nxt.half = 4'h0;
               state_nxt.sclk = 1'b1;
               state_nxt.st   = srcp_pkg::SRCP_CTL_HIGH;
            end
         end
         srcp_pkg::SRCP_CTL_HIGH: begin
            if (state_r.half == 4'(`SRCP_SCLK_HALF - 1)) begin
               state_nxt.half = 4'h0;
               state_nxt.sclk = 1'b0;                        // R17
               state_nxt.bitn = state_r.bitn + 5'h1;
               state_nxt.shreg = {state_r.shreg[14:0], 1'b0}; // R1
               // bit 7 is launched on the eighth rise, so sample falls eight to fifteen
               if (state_r.bitn >= 5'h7 && state_r.bitn <= 5'he) begin // R17
                  state_nxt.rdata = {state_r.rdata[6:0], state_r.io_s[1]};
               end
               state_nxt.st = (state_r.bitn == 5'(`SRCP_FRAME_BITS - 1)) ?
                              srcp_pkg::SRCP_CTL_END : srcp_pkg::SRCP_CTL_LOW;
            end
         end
         srcp_pkg::SRCP_CTL_END: begin
            state_nxt.cs_n = 1'b1;
            state_nxt.done = 1'b1;
            state_nxt.st   = srcp_pkg::SRCP_CTL_IDLE;
         end
         default: begin
            state_nxt.st = srcp_pkg::SRCP_CTL_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state_r      <= '0;
         state_r.cs_n <= 1'b1;                               // R16
         state_r.st   <= srcp_pkg::SRCP_CTL_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign o_req_ready    = (state_r.st == srcp_pkg::SRCP_CTL_IDLE);
   assign o_done         = state_r.done;
   assign o_rdata        = state_r.rdata;
   assign link.sclk      = state_r.sclk;
   assign link.cs_n      = state_r.cs_n;
   assign link.rd_wr     = state_r.rd;                       // R7
   assign link.io_ctl_o  = state_r.shreg[15];
   // on reads let go two cycles into the eighth high phase: the device has
   // taken the last address bit by then and starts driving one cycle later
   assign link.io_ctl_oe = ~state_r.cs_n &
                           ~(state_r.rd && (state_r.bitn >= 5'h8 ||
                             (state_r.bitn == 5'h7 && state_r.sclk &&
                              state_r.half >= 4'h2)));       // R3
endmodule : srcp_controller

// [tb/srcp_sva.sv]
/*
 checker for the serial control link: clocking, framing and data pin
 ownership seen on the interface wires.
 assumes one system clock domain, instantiated beside the interface.
*/
`timescale 1ns/1ps
module srcp_sva (
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_reset_n,
   // link wires
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic rd_wr,
   input wire logic io_ctl_o,
   input wire logic io_ctl_oe,
   input wire logic io_dev_o,
   input wire logic io_dev_oe,
   input wire logic io_i
);
   logic [4:0] rise_cnt_r;
   logic       sclk_d_r;
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_reset_n);
   // counts raw rising edges, ahead of the device's synchroniser
   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         rise_cnt_r <= 5'h00;
         sclk_d_r   <= 1'b0;
      end else begin
         sclk_d_r <= sclk;
         if (cs_n) begin
            rise_cnt_r <= 5'h00;
         end else if (sclk && !sclk_d_r) begin
            rise_cnt_r <= rise_cnt_r + 5'h01;
         end
      end
   end
   // depth 4 allows for the device's select synchroniser lag
   a_dev_oe_read: assert property (io_dev_oe |-> rd_wr || $past(rd_wr, 4))
      else $error("device drives data pin during a write");
   a_dev_oe_select: assert property (io_dev_oe |-> !cs_n || !$past(cs_n, 4))
      else $error("device drives data pin while not selected");
   a_dev_oe_phase: assert property (io_dev_oe && !cs_n |-> rise_cnt_r >= 5'h08)
      else $error("device drives data pin during the address byte");
   a_pin_no_clash: assert property (!(io_dev_oe && io_ctl_oe))
      else $error("both ends drive the data pin");
   a_ctl_data_hold: assert property (sclk && $past(sclk) && io_ctl_oe |-> $stable(io_ctl_o))
      else $error("controller data moves while serial clock high");
   a_dev_launch_rise: assert property (
      io_dev_oe && $past(io_dev_oe) && $changed(io_dev_o) |-> sclk)
      else $error("device read data moves while serial clock low");
   a_sclk_high_len: assert property ($rose(sclk) |-> sclk [*6] ##1 !sclk)
      else $error("serial clock high phase not six cycles");
   a_sclk_idle_low: assert property (cs_n |-> !sclk)
      else $error("serial clock runs outside a frame");
   a_frame_sixteen: assert property ($rose(cs_n) |-> rise_cnt_r == 5'h10)
      else $error("frame did not carry sixteen bits");
   a_dir_steady: assert property (!cs_n && $past(!cs_n) |-> $stable(rd_wr))
      else $error("direction changed inside a frame");
endmodule : srcp_sva

// [tb/tb_top.sv]
/*
 testbench joining controller and device through the link interface;
 requests go in on the controller's request side, wire frames are watched.
 assumes the data pin pulls high when neither end drives it.
*/
`timescale 1ns/1ps
module tb_top;
   logic        i_sys_clk;
   logic        i_reset_n;
   logic        i_clk_div4_sel;
   logic [6:0]  i_reg_view_index;
   logic [7:0]  o_reg_view_data;
   logic        i_req_valid;
   logic        i_req_read;
   logic [7:0]  i_req_addr;
   logic [7:0]  i_req_wdata;
   logic        o_req_ready;
   logic        o_done;
   logic [7:0]  o_rdata;
   logic        o_xcvr_enable;
   logic        o_standby;
   logic        o_xcvr_clk;
   logic [15:0] shift_q;
   logic [15:0] frame_q;
   int          n_fail;
   int          num_checks;

   srcp_if link_if ();
   // pull-up when no end drives the pin
   assign link_if.io_i = link_if.io_dev_oe ? link_if.io_dev_o :
                         (link_if.io_ctl_oe ? link_if.io_ctl_o : 1'b1);
   srcp_device i_srcp_device (.i_sys_clk, .i_reset_n, .link(link_if), .i_clk_div4_sel,
      .o_xcvr_enable, .o_standby, .o_xcvr_clk, .o_reg_view_data, .i_reg_view_index);
   srcp_controller i_srcp_controller (.i_sys_clk, .i_reset_n, .i_req_valid, .i_req_read,
      .i_req_addr, .i_req_wdata, .o_req_ready, .o_done, .o_rdata, .link(link_if));
   srcp_sva i_srcp_sva (.i_sys_clk, .i_reset_n, .sclk(link_if.sclk), .cs_n(link_if.cs_n),
      .rd_wr(link_if.rd_wr), .io_ctl_o(link_if.io_ctl_o), .io_ctl_oe(link_if.io_ctl_oe),
      .io_dev_o(link_if.io_dev_o), .io_dev_oe(link_if.io_dev_oe), .io_i(link_if.io_i));

   // wire-level frame capture, independent of both ends
   always @(posedge link_if.sclk) begin
      if (!link_if.cs_n) begin
         shift_q <= {shift_q[14:0], link_if.io_i};
      end
   end
   always @(posedge link_if.cs_n) begin
      frame_q <= shift_q;
   end

   initial begin
      i_sys_clk = 1'b0;
      forever #4 i_sys_clk = ~i_sys_clk;
   end

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : wrap_up

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // d is write data, or the expected read data
   task automatic xfer(input logic rd, input logic [7:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(negedge i_sys_clk);
      i_req_valid = 1'b1;
      i_req_read  = rd;
      i_req_addr  = a;
      i_req_wdata = rd ? 8'h00 : d;
      @(posedge i_sys_clk);
      while (o_req_ready !== 1'b1 && n < 50) begin
         @(posedge i_sys_clk);
         n++;
      end
      @(negedge i_sys_clk);
      i_req_valid = 1'b0;
      while (o_done !== 1'b1 && n < 400) begin
         @(negedge i_sys_clk);
         n++;
         if (n == 100) begin
            chk({14'h0000, o_standby, o_xcvr_enable}, 16'h0001);
         end
      end
      if (n >= 400) begin
         n_fail++;
         wrap_up();
      end
      if (rd) begin
         chk({8'h00, o_rdata}, {8'h00, d});
      end
      chk(frame_q, {a, d});
   endtask : xfer

   task automatic clk_rate(input logic div4);
      int   r;
      logic p;
      r = 0;
      @(negedge i_sys_clk);
      i_clk_div4_sel = div4;
      repeat (8) @(negedge i_sys_clk);
      p = o_xcvr_clk;
      repeat (40) begin
         @(negedge i_sys_clk);
         if (o_xcvr_clk === 1'b1 && p === 1'b0) begin
            r++;
         end
         p = o_xcvr_clk;
      end
      chk(16'(r), div4 ? 16'h000a : 16'h0014);
   endtask : clk_rate

   initial begin
      n_fail           = 0;
      num_checks       = 0;
      i_reset_n        = 1'b0;
      i_clk_div4_sel   = 1'b0;
      i_reg_view_index = 7'h00;
      i_req_valid      = 1'b0;
      i_req_read       = 1'b0;
      i_req_addr       = 8'h00;
      i_req_wdata      = 8'h00;
      repeat (4) @(negedge i_sys_clk);
      chk({14'h0000, o_standby, o_xcvr_enable}, 16'h0002);
      i_reset_n = 1'b1;
      repeat (4) @(negedge i_sys_clk);
      chk({14'h0000, o_standby, o_xcvr_enable}, 16'h0001);
      // odd write addresses, even read addresses: bit zero must not matter
      for (int i = 0; i < 4; i++) begin
         xfer(1'b0, 8'h21 + 8'(2 * i), 8'h81 ^ 8'(17 * i));
      end
      for (int i = 0; i < 4; i++) begin
         xfer(1'b1, 8'h20 + 8'(2 * i), 8'h81 ^ 8'(17 * i));
      end
      i_reg_view_index = 7'h10;
      repeat (2) @(negedge i_sys_clk);
      chk({8'h00, o_reg_view_data}, 16'h0081);
      $display("test write and read back done");
      xfer(1'b0, 8'h42, 8'h3c);
      i_reset_n = 1'b0;
      repeat (4) @(negedge i_sys_clk);
      chk({14'h0000, o_standby, o_xcvr_enable}, 16'h0002);
      i_reset_n = 1'b1;
      repeat (4) @(negedge i_sys_clk);
      xfer(1'b1, 8'h42, 8'h3c);
      $display("test reset keeps registers done");
      clk_rate(1'b0);
      clk_rate(1'b1);
      $display("test transceiver clock done");
      wrap_up();
   end
endmodule : tb_top
